// [design/arfm_pkg.sv]
package arfm_pkg;

    // ------------------------------------------------------------
    // input channel select codes
    // ------------------------------------------------------------
    localparam logic [4:0] CH_PAD    = 5'h00;
    localparam logic [4:0] CH_TEMP   = 5'h1B;
    localparam logic [4:0] CH_SUPPLY = 5'h1C;
    localparam logic [4:0] CH_LDO    = 5'h1D;
    localparam logic [4:0] CH_GND    = 5'h1F;

    // ------------------------------------------------------------
    // route one-hot positions
    // ------------------------------------------------------------
    localparam int ROUTE_W    = 5;
    localparam int RT_PAD     = 0;
    localparam int RT_TEMP    = 1;
    localparam int RT_SUPPLY  = 2;
    localparam int RT_LDO     = 3;
    localparam int RT_GND     = 4;

    // ------------------------------------------------------------
    // repeat count select codes
    // ------------------------------------------------------------
    localparam logic [2:0] RPT_1  = 3'h0;
    localparam logic [2:0] RPT_4  = 3'h1;
    localparam logic [2:0] RPT_8  = 3'h2;
    localparam logic [2:0] RPT_16 = 3'h3;
    localparam logic [2:0] RPT_32 = 3'h4;
    localparam logic [2:0] RPT_64 = 3'h5;

    // ------------------------------------------------------------
    // justify / shift field
    // ------------------------------------------------------------
    localparam int          JUST_LEFT_BIT = 2;
    localparam logic [2:0]  JUST_RIGHT    = 3'h0;
    localparam int          LEFT_POS      = 6;
    localparam logic [15:0] RESULT_RST    = 16'h0000;
    localparam logic [6:0]  COUNT_ZERO    = 7'h00;

    // ------------------------------------------------------------
    // samples per series
    // ------------------------------------------------------------
    localparam logic [6:0] CNT_1  = 7'h01;
    localparam logic [6:0] CNT_4  = 7'h04;
    localparam logic [6:0] CNT_8  = 7'h08;
    localparam logic [6:0] CNT_16 = 7'h10;
    localparam logic [6:0] CNT_32 = 7'h20;
    localparam logic [6:0] CNT_64 = 7'h40;

    typedef enum logic [2:0] {
        ARFM_IDLE  = 3'b001,
        ARFM_WAIT  = 3'b010,
        ARFM_CONV  = 3'b100
    } arfm_state_t;

endpackage : arfm_pkg

// [design/arfm_acc_if.sv]
`timescale 1ns/1ps
interface arfm_acc_if;
    logic        clear;
    logic        add;
    logic [9:0]  sample;
    logic [15:0] sum;

    modport ctrl (output clear, output add, output sample, input sum);
    modport acc  (input clear, input add, input sample, output sum);
endinterface : arfm_acc_if

// [design/arfm_accum.sv]
`timescale 1ns/1ps
module arfm_accum (
    // clock and reset
    input  wire logic clock_in,
    input  wire logic rstn_in,
    // accumulator port
    arfm_acc_if.acc   acc
);
    logic [15:0] sum_r;
    logic [15:0] sum_nxt;

    // ------------------------------------------------------------
    // accumulate, with clear folding in the first sample
    // ------------------------------------------------------------
    always_comb begin
        sum_nxt = sum_r;
        if (acc.add) begin
            if (acc.clear) begin
                sum_nxt = {6'h00, acc.sample};
            end else begin
                sum_nxt = sum_r + {6'h00, acc.sample};
            end
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sum_r <= arfm_pkg::RESULT_RST;
        end else begin
            sum_r <= sum_nxt;
        end
    end

    assign acc.sum = sum_nxt;
endmodule : arfm_accum

// [design/arfm_top.sv]
// Notes on behaviour
// - channel code 00000 pad, 11011 temp, 11100 supply, 11101 regulator, 11111 ground.
// - repeat count one gives a 10-bit unsigned result in the byte pair.
// - justify 000 puts code in bits 9:0, 100 in bits 15:6.
// - result bits unused by the current format read as zero.
// - with repeats, result holds the series sum, updated only at its end.
// - repeat select picks 4, 8, 16, 32 or 64 samples.
// - justify field shifts accumulator right by 1, 2 or 3 places.
// - done flag sets only after repeat-count conversions accumulated.
// - burst start launches repeat-count conversions; else one per start.
// - window compare runs only after the full series.
`timescale 1ns/1ps
module arfm_top (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    // configuration
    input  wire logic [4:0]  input_channel_select_in,
    input  wire logic [2:0]  result_justify_shift_in,
    input  wire logic [2:0]  repeat_count_select_in,
    input  wire logic        burst_enable_in,
    input  wire logic        done_clear_in,
    // converter handshake
    input  wire logic        conv_start_in,
    input  wire logic        conv_valid_in,
    input  wire logic [9:0]  conv_code_in,
    // window thresholds
    input  wire logic [15:0] window_low_in,
    input  wire logic [15:0] window_high_in,
    // analog route
    output logic [4:0]       route_sel_out,
    output logic             route_invalid_out,
    output logic             conv_request_out,
    // result
    output logic [7:0]       result_high_byte_out,
    output logic [7:0]       result_low_byte_out,
    output logic             conversion_done_flag_out,
    output logic             window_hit_out
);
    // ------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------
    // the adder lives in its own module so its width can grow without touching the sequencer
    arfm_acc_if acc_bus ();

    arfm_accum u_accum (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .acc      (acc_bus)
    );

    // ------------------------------------------------------------
    // sequencer and result state
    // ------------------------------------------------------------
    // states are one-hot so a stray code falls into the default branch
    arfm_pkg::arfm_state_t state_r;
    arfm_pkg::arfm_state_t state_nxt;
    logic [6:0]  cnt_r;
    logic [6:0]  cnt_nxt;
    logic [6:0]  target;
    logic [4:0]  route_r;
    logic [4:0]  route_nxt;
    logic        inval_r;
    logic        inval_nxt;
    logic        req_r;
    logic        req_nxt;
    logic [15:0] res_r;
    logic [15:0] res_nxt;
    logic        done_r;
    logic        done_nxt;
    logic        win_r;
    logic        win_nxt;
    logic        last;
    logic [15:0] fmt;

    // ------------------------------------------------------------
    // repeat count decode
    // ------------------------------------------------------------
    always_comb begin
        // reserved repeat codes fall back to single samples
        case (repeat_count_select_in)
            arfm_pkg::RPT_4:  target = arfm_pkg::CNT_4;
            arfm_pkg::RPT_8:  target = arfm_pkg::CNT_8;
            arfm_pkg::RPT_16: target = arfm_pkg::CNT_16;
            arfm_pkg::RPT_32: target = arfm_pkg::CNT_32;
            arfm_pkg::RPT_64: target = arfm_pkg::CNT_64;
            default:          target = arfm_pkg::CNT_1;
        endcase
    end

    // ------------------------------------------------------------
    // channel routing
    // ------------------------------------------------------------
    always_comb begin
        route_nxt = '0;
        inval_nxt = 1'b0;
        // reserved codes leave every route line low rather than fall back to some input
        case (input_channel_select_in)
            arfm_pkg::CH_PAD:    route_nxt[arfm_pkg::RT_PAD]    = 1'b1;
            arfm_pkg::CH_TEMP:   route_nxt[arfm_pkg::RT_TEMP]   = 1'b1;
            arfm_pkg::CH_SUPPLY: route_nxt[arfm_pkg::RT_SUPPLY] = 1'b1;
            arfm_pkg::CH_LDO:    route_nxt[arfm_pkg::RT_LDO]    = 1'b1;
            arfm_pkg::CH_GND:    route_nxt[arfm_pkg::RT_GND]    = 1'b1;
            default:             inval_nxt = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // result formatting
    // ------------------------------------------------------------
    // left justify only meaningful for single samples; the shift
    // codes 1..3 apply to the accumulator in either case
    // with repeats and left justify only the low ten bits of the sum show: a software error
    always_comb begin
        if (result_justify_shift_in[arfm_pkg::JUST_LEFT_BIT]) begin
            fmt = {acc_bus.sum[9:0], 6'h00};
        end else begin
            fmt = acc_bus.sum >> result_justify_shift_in[1:0];
        end
    end

    // ------------------------------------------------------------
    // series sequencer
    // ------------------------------------------------------------
    // the sum is read before it is registered so the final sample lands with the result
    assign last           = (cnt_r + arfm_pkg::CNT_1) >= target;
    assign acc_bus.add    = (state_r == arfm_pkg::ARFM_CONV) && conv_valid_in;
    assign acc_bus.clear  = (cnt_r == arfm_pkg::COUNT_ZERO);
    assign acc_bus.sample = conv_code_in;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        req_nxt   = 1'b0;
        res_nxt   = res_r;
        win_nxt   = win_r;
        done_nxt  = done_r & ~done_clear_in;
        case (state_r)
            arfm_pkg::ARFM_IDLE: begin
                // a new series always restarts the count, whatever a cut series left
                if (conv_start_in) begin
                    req_nxt   = 1'b1;
                    cnt_nxt   = arfm_pkg::COUNT_ZERO;
                    state_nxt = arfm_pkg::ARFM_CONV;
                end
            end
            arfm_pkg::ARFM_WAIT: begin
                if (conv_start_in) begin
                    req_nxt   = 1'b1;
                    state_nxt = arfm_pkg::ARFM_CONV;
                end
            end
            // starts that arrive while a conversion is in flight are dropped, not queued
            arfm_pkg::ARFM_CONV: begin
                if (conv_valid_in) begin
                    if (last) begin
                        cnt_nxt   = arfm_pkg::COUNT_ZERO;
                        res_nxt   = fmt;
                        // the set wins over a clear in the same cycle so no finished series is lost
                        done_nxt  = 1'b1;
                        win_nxt   = (fmt >= window_low_in) && (fmt <= window_high_in);
                        state_nxt = arfm_pkg::ARFM_IDLE;
                    end else begin
                        cnt_nxt = cnt_r + arfm_pkg::CNT_1;
                        if (burst_enable_in) begin
                            req_nxt = 1'b1;
                        end else begin
                            state_nxt = arfm_pkg::ARFM_WAIT;
                        end
                    end
                end
            end
            default: begin
                state_nxt = arfm_pkg::ARFM_IDLE;
                cnt_nxt   = arfm_pkg::COUNT_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // one flop behind every output, so nothing combinational reaches a pin
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= arfm_pkg::ARFM_IDLE;
            cnt_r   <= arfm_pkg::COUNT_ZERO;
            route_r <= '0;
            inval_r <= 1'b0;
            req_r   <= 1'b0;
            res_r   <= arfm_pkg::RESULT_RST;
            done_r  <= 1'b0;
            win_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            route_r <= route_nxt;
            inval_r <= inval_nxt;
            req_r   <= req_nxt;
            res_r   <= res_nxt;
            done_r  <= done_nxt;
            win_r   <= win_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign route_sel_out            = route_r;
    assign route_invalid_out        = inval_r;
    assign conv_request_out         = req_r;
    assign result_high_byte_out     = res_r[15:8];
    assign result_low_byte_out      = res_r[7:0];
    assign conversion_done_flag_out = done_r;
    assign window_hit_out           = win_r;
endmodule : arfm_top

// [bench/arfm_conv_model.sv]
`timescale 1ns/1ps
module arfm_conv_model (
    input  wire logic       clock_in,
    input  wire logic       rstn_in,
    input  wire logic       req_in,
    input  wire logic       slow_in,
    input  wire logic [9:0] code_in,
    output logic            valid_out,
    output logic [9:0]      code_out
);
    logic [2:0] pipe_r;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pipe_r <= 3'h0;
        end else begin
            pipe_r <= {pipe_r[1:0], req_in};
        end
    end
    // code only holds with the strobe; the inverse elsewhere so a stale sample cannot pass
    assign valid_out = slow_in ? pipe_r[2] : pipe_r[1];
    assign code_out  = valid_out ? code_in : ~code_in;
endmodule : arfm_conv_model

// [bench/arfm_top_checker.sv]
`timescale 1ns/1ps
module arfm_top_checker (
    input wire logic       clock_in, rstn_in, done_clear_in, conv_start_in, conv_valid_in,
    input wire logic [4:0] input_channel_select_in, route_sel_out,
    input wire logic [2:0] result_justify_shift_in, repeat_count_select_in,
    input wire logic       route_invalid_out, conv_request_out, conversion_done_flag_out, window_hit_out,
    input wire logic [7:0] result_high_byte_out, result_low_byte_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    chk_route_pad: assert property (rstn_in && input_channel_select_in == 5'h00 |=> route_sel_out == 5'h01)
        else $error("pad route wrong");
    chk_route_temp: assert property (rstn_in && input_channel_select_in == 5'h1B |=> route_sel_out == 5'h02)
        else $error("temperature route wrong");
    chk_reserved_code: assert property (rstn_in
        && !(input_channel_select_in inside {5'h00, 5'h1B, 5'h1C, 5'h1D, 5'h1F})
        |=> route_invalid_out && route_sel_out == 5'h00) else $error("reserved code routed");
    chk_done_cause: assert property ($rose(conversion_done_flag_out) |-> $past(conv_valid_in))
        else $error("done without conversion");
    chk_done_sticky: assert property (conversion_done_flag_out && !done_clear_in |=> conversion_done_flag_out)
        else $error("done dropped");
    chk_req_cause: assert property (conv_request_out |-> $past(conv_start_in) || $past(conv_valid_in))
        else $error("request without cause");
    chk_result_hold: assert property (rstn_in && !$past(conv_valid_in)
        |-> $stable({result_high_byte_out, result_low_byte_out})) else $error("result changed mid series");
    chk_right_fmt: assert property ($changed({result_high_byte_out, result_low_byte_out})
        && $past(result_justify_shift_in) == 3'h0 && $past(repeat_count_select_in) == 3'h0
        |-> result_high_byte_out[7:2] == 6'h00) else $error("right format upper bits set");
    chk_left_fmt: assert property ($changed({result_high_byte_out, result_low_byte_out})
        && $past(result_justify_shift_in[2]) |-> result_low_byte_out[5:0] == 6'h00)
        else $error("left format lower bits set");
    chk_window_time: assert property (rstn_in && $changed(window_hit_out) |-> $past(conv_valid_in))
        else $error("window changed mid series");
endmodule : arfm_top_checker
bind arfm_top arfm_top_checker i_arfm_top_checker (.*);

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic        clock_in, rstn_in, burst_enable_in, done_clear_in, conv_start_in, conv_valid_in, slow;
    logic [4:0]  input_channel_select_in, route_sel_out;
    logic [2:0]  result_justify_shift_in, repeat_count_select_in;
    logic [9:0]  conv_code_in, code;
    logic [15:0] window_low_in, window_high_in;
    logic        route_invalid_out, conv_request_out, conversion_done_flag_out, window_hit_out;
    logic [7:0]  result_high_byte_out, result_low_byte_out;
    int          err_total, cmp_count, nv;
    // ------------------------------------------------------------
    // rows: repeat, justify, code, expected result
    // ------------------------------------------------------------
    logic [31:0] rows [13] = '{32'h03FF03FF, 32'h13FFFFC0, 32'h12008000, 32'h23FF0FFC, 32'h42001000,
        32'h61FF1FF0, 32'h83FF7FE0, 32'hA3FFFFC0, 32'h27FF07FE, 32'h6BFF0FFC, 32'hAFFF1FF8, 32'h0FFF007F,
        32'h40000000};
    logic [9:0]  chs [7] = '{10'h001, 10'h362, 10'h384, 10'h3A8, 10'h3F0, 10'h0A0, 10'h3C0};
    arfm_top i_arfm_top (.*);
    arfm_conv_model i_arfm_conv_model (.clock_in, .rstn_in, .req_in(conv_request_out), .slow_in(slow),
        .code_in(code), .valid_out(conv_valid_in), .code_out(conv_code_in));
    initial begin
        clock_in = 0;
        forever #10 clock_in = ~clock_in;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    // right justify whenever repeats exceed one: rows keep it
    task run(input logic [31:0] r, input logic b);
        int n;
        repeat_count_select_in <= r[31:29];
        result_justify_shift_in <= r[28:26];
        code <= r[25:16];
        burst_enable_in <= b;
        done_clear_in <= 1;
        @(posedge clock_in);
        done_clear_in <= 0;
        nv = 0;
        n = 0;
        while (n < 1000) begin
            conv_start_in <= (n == 0) || (!b && n % 8 == 0);
            @(negedge clock_in);
            nv += conv_valid_in;
            n++;
            if (conversion_done_flag_out === 1'b1) break;
            @(posedge clock_in);
        end
        chk(nv, (r[31:29] == 0) ? 1 : (1 << (r[31:29] + 1)), "count");
        chk({result_high_byte_out, result_low_byte_out}, r[15:0], "result");
        chk(window_hit_out, r[15:0] >= 16'h0800 && r[15:0] <= 16'h1000, "window");
        @(posedge clock_in);
        conv_start_in <= 0;
        $display("test done: series %h burst %0d", r, b);
    endtask : run
    initial begin
        {rstn_in, burst_enable_in, done_clear_in, conv_start_in, slow} = 0;
        {input_channel_select_in, result_justify_shift_in, repeat_count_select_in, code} = 0;
        window_low_in = 16'h0800;
        window_high_in = 16'h1000;
        err_total = 0;
        cmp_count = 0;
        repeat (3) @(posedge clock_in);
        rstn_in <= 1;
        @(negedge clock_in);
        chk({route_sel_out, route_invalid_out, conv_request_out, result_high_byte_out, result_low_byte_out,
            conversion_done_flag_out, window_hit_out}, 0, "reset");
        $display("test done: reset");
        // no pad selector is raised for internal codes, at most one for the pad code
        foreach (chs[i]) begin
            @(posedge clock_in);
            input_channel_select_in <= chs[i][9:5];
            repeat (2) @(negedge clock_in);
            chk({route_invalid_out, route_sel_out}, {chs[i][4:0] == 0, chs[i][4:0]}, "route");
        end
        $display("test done: channels");
        foreach (rows[i]) begin
            @(posedge clock_in);
            slow <= i[0];
            run(rows[i], 1);
        end
        run(32'h21000400, 0);
        // ------------------------------------------------------------
        // reset in mid series, then a clean series
        // ------------------------------------------------------------
        @(posedge clock_in);
        repeat_count_select_in <= 3'h5;
        burst_enable_in <= 1;
        conv_start_in <= 1;
        @(posedge clock_in);
        conv_start_in <= 0;
        repeat (20) @(posedge clock_in);
        rstn_in <= 0;
        @(negedge clock_in);
        chk({conv_request_out, result_high_byte_out, result_low_byte_out, conversion_done_flag_out}, 0, "mid reset");
        $display("test done: mid reset");
        @(posedge clock_in);
        rstn_in <= 1;
        @(posedge clock_in);
        run(rows[3], 1);
        tally_and_finish();
    end
    initial begin
        #1000000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb_top
